// *** verilog/timer_init_status_mode_regs.sv ***
// Start value, channel flag mirror and feature mode registers
`timescale 1ns/1ps
`default_nettype none

module timer_init_status_mode_regs
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic        buffer_update,
  input  wire logic [7:0]  channel_event,
  input  wire logic        fault_pin,
  output logic      [15:0] counter_initial_value,
  output logic      [1:0]  clock_source_select,
  output logic             count_load,
  output logic      [15:0] count_load_value,
  output logic      [7:0]  channel_event_flag,
  output logic      [7:0]  fault_channel_enable,
  output logic             fault_auto_clear,
  output logic             fault_irq
);

  ////////////////////////////////////////////////////////////////////
  // Decode

  logic        wr_start;
  logic        wr_flags;
  logic        wr_mode;
  logic        wr_prot;
  logic        wr_clk;
  logic        wr_count;
  logic        rd_flags;
  logic        rd_prot;

  assign wr_start = wr_stb && (addr == timer_regs_pkg::OFF_START_VALUE);
  assign wr_flags = wr_stb && (addr == timer_regs_pkg::OFF_FLAG_MIRROR);
  assign wr_mode  = wr_stb && (addr == timer_regs_pkg::OFF_MODE);
  assign wr_prot  = wr_stb && (addr == timer_regs_pkg::OFF_PROTECT);
  assign wr_clk   = wr_stb && (addr == timer_regs_pkg::OFF_CLOCK_SEL);
  assign wr_count = wr_stb && (addr == timer_regs_pkg::OFF_COUNTER);
  assign rd_flags = rd_stb && (addr == timer_regs_pkg::OFF_FLAG_MIRROR);
  assign rd_prot  = rd_stb && (addr == timer_regs_pkg::OFF_PROTECT);

  ////////////////////////////////////////////////////////////////////
  // Start value with holding buffer

  logic [15:0] start_buf_r;
  logic [15:0] start_vis_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      start_buf_r <= timer_regs_pkg::START_RESET;
    else if (wr_start)
      start_buf_r <= wdata[15:0]; // [RL4] [RL18]
  end

  // Buffer passes straight through while no clock is selected
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      start_vis_r <= timer_regs_pkg::START_RESET;
    else if (buffer_update || clock_source_select == 2'h0)
      start_vis_r <= start_buf_r; // [RL1]
  end

  assign counter_initial_value = start_vis_r;

  ////////////////////////////////////////////////////////////////////
  // Clock select and counter load

  logic        count_written_r;
  logic        first_select;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      clock_source_select <= timer_regs_pkg::CLKSEL_RESET;
    else if (wr_clk)
      clock_source_select <= wdata[1:0];
  end

  assign first_select = wr_clk && (clock_source_select == 2'h0)
                        && (wdata[1:0] != 2'h0);

  // Remembers a counter write since reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      count_written_r <= 1'b0;
    else if (wr_count)
      count_written_r <= 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_load       <= 1'b0;
      count_load_value <= timer_regs_pkg::COUNT_FIRST;
    end
    else if (wr_count)
    begin
      count_load       <= 1'b1;
      count_load_value <= start_vis_r; // [RL3]
    end
    else if (first_select && !count_written_r)
    begin
      count_load       <= 1'b1;
      count_load_value <= timer_regs_pkg::COUNT_FIRST; // [RL2]
    end
    else
      count_load <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Channel flags

  logic [7:0]  flags_r;
  logic [7:0]  armed_r;
  logic [7:0]  flag_clr;

  // Only bits seen set by a read, with no new event, may clear
  assign flag_clr = wr_flags ? (armed_r & ~wdata[7:0] & ~channel_event)
                             : 8'h00; // [RL6] [RL8] [RL9]

  // Set wins over clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      flags_r <= timer_regs_pkg::FLAGS_RESET;
    else
      flags_r <= (flags_r & ~flag_clr) | channel_event; // [RL7]
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      armed_r <= timer_regs_pkg::FLAGS_RESET;
    else if (wr_flags)
      armed_r <= 8'h00;
    else if (rd_flags)
      armed_r <= flags_r & ~channel_event;
    else
      armed_r <= armed_r & ~channel_event; // [RL9]
  end

  assign channel_event_flag = flags_r; // [RL5]

  ////////////////////////////////////////////////////////////////////
  // Mode and write protection

  logic        fie_r;
  logic [1:0]  fcm_r;
  logic        wp_off_r;
  logic        wp_armed_r;
  logic        fault_s1_r;
  logic        fault_s2_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fie_r <= timer_regs_pkg::FIE_RESET;
    else if (wr_mode)
      fie_r <= wdata[timer_regs_pkg::MODE_FIE_BIT];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fcm_r <= timer_regs_pkg::FCM_RESET;
    else if (wr_mode && wp_off_r)
      fcm_r <= wdata[timer_regs_pkg::MODE_FCM_LSB +: 2]; // [RL14]
  end

  // Arming needs a read of the enable bit while it shows one
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wp_armed_r <= 1'b0;
    else if (wr_prot || wp_off_r)
      wp_armed_r <= 1'b0;
    else if (rd_prot)
      wp_armed_r <= 1'b1;
  end

  // Enabling protection has priority over a disable
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wp_off_r <= timer_regs_pkg::WP_OFF_RESET;
    else if (wr_prot && wdata[timer_regs_pkg::PROT_WP_ON_BIT])
      wp_off_r <= 1'b0; // [RL17]
    else if (wr_mode && wp_armed_r && wdata[timer_regs_pkg::MODE_WP_OFF_BIT])
      wp_off_r <= 1'b1; // [RL17]
  end

  // Fault pin is asynchronous to the bus clock
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fault_s1_r <= 1'b0;
      fault_s2_r <= 1'b0;
    end
    else
    begin
      fault_s1_r <= fault_pin;
      fault_s2_r <= fault_s1_r;
    end
  end

  // One setting drives every channel
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fault_channel_enable <= 8'h00;
      fault_auto_clear     <= 1'b0;
    end
    else
    begin
      case (fcm_r)
        timer_regs_pkg::FCM_OFF:
          fault_channel_enable <= 8'h00; // [RL15] [RL12]
        timer_regs_pkg::FCM_EVEN_MANUAL:
          fault_channel_enable <= timer_regs_pkg::EVEN_CHANNELS; // [RL15]
        default:
          fault_channel_enable <= timer_regs_pkg::ALL_CHANNELS; // [RL16]
      endcase
      fault_auto_clear <= (fcm_r == timer_regs_pkg::FCM_ALL_AUTO); // [RL16]
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_irq <= 1'b0;
    else
      fault_irq <= fie_r && (fcm_r != timer_regs_pkg::FCM_OFF)
                   && fault_s2_r; // [RL13]
  end

  ////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  logic [31:0] rd_nxt;

  always_comb
  begin
    rd_nxt = 32'h0000_0000; // [RL18]
    case (addr)
      timer_regs_pkg::OFF_START_VALUE:
        rd_nxt[15:0] = start_vis_r; // [RL4]
      timer_regs_pkg::OFF_FLAG_MIRROR:
        rd_nxt[7:0] = flags_r; // [RL5] [RL11]
      timer_regs_pkg::OFF_MODE:
      begin
        rd_nxt[timer_regs_pkg::MODE_FIE_BIT]      = fie_r;
        rd_nxt[timer_regs_pkg::MODE_FCM_LSB +: 2] = fcm_r;
        rd_nxt[timer_regs_pkg::MODE_WP_OFF_BIT]   = wp_off_r;
      end
      timer_regs_pkg::OFF_PROTECT:
        rd_nxt[timer_regs_pkg::PROT_WP_ON_BIT] = ~wp_off_r;
      timer_regs_pkg::OFF_CLOCK_SEL:
        rd_nxt[1:0] = clock_source_select;
      default:
        rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata <= 32'h0000_0000;
    else if (rd_stb)
      rdata <= rd_nxt;
    else
      rdata <= 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_flag_read;
    rd_flags && channel_event == 8'h00;
  endsequence

  sequence s_flag_zero_write;
    wr_flags && wdata[7:0] == 8'h00 && channel_event == 8'h00;
  endsequence

  chk_start_held: assert property ( // [RL1]
    wr_start && !buffer_update && clock_source_select != 2'h0
    ##1 !buffer_update |=> $stable(start_vis_r))
    else $error("start value changed without update");

  chk_first_zero: assert property ( // [RL2]
    first_select && !count_written_r && !wr_count
    |=> count_load && count_load_value == 16'h0000)
    else $error("first clock select did not load zero");

  chk_start_upper: assert property ( // [RL4]
    rd_stb && addr == timer_regs_pkg::OFF_START_VALUE
    |=> rdata[31:16] == 16'h0000 && rdata[15:0] == $past(start_vis_r))
    else $error("start value readback wrong");

  chk_mirror_read: assert property ( // [RL5]
    rd_flags |=> rdata[7:0] == $past(flags_r) && rdata[31:8] == 24'h0)
    else $error("flag mirror readback wrong"); // [RL11]

  chk_clear_seq: assert property ( // [RL6]
    s_flag_read ##1 s_flag_zero_write |=> flags_r == 8'h00)
    else $error("read then zero write left flags set");

  chk_event_sets: assert property ( // [RL7]
    channel_event != 8'h00 |=> (flags_r & $past(channel_event)) == $past(channel_event))
    else $error("event did not set flag");

  chk_no_blind_clear: assert property ( // [RL8]
    wr_flags && armed_r == 8'h00 |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("flag cleared without prior read");

  chk_event_kept: assert property ( // [RL9]
    rd_flags ##1 (channel_event != 8'h00) ##1 wr_flags
    |=> (flags_r & $past(channel_event, 2)) == $past(channel_event, 2))
    else $error("event between read and write lost");

  chk_fcm_locked: assert property ( // [RL14]
    !wp_off_r |=> $stable(fcm_r))
    else $error("fault mode changed under protection");

  chk_fault_irq: assert property ( // [RL13]
    !fie_r || fcm_r == 2'h0 |=> !fault_irq)
    else $error("fault interrupt while disabled");

  chk_even_only: assert property ( // [RL15]
    fcm_r == 2'h1 ##1 $stable(fcm_r) |-> fault_channel_enable == 8'h55 && !fault_auto_clear)
    else $error("even-channel mode wrong");

  chk_auto_mode: assert property ( // [RL16]
    fcm_r == 2'h3 ##1 $stable(fcm_r) |-> fault_channel_enable == 8'hff && fault_auto_clear)
    else $error("automatic mode wrong");

  chk_protect_gate: assert property ( // [RL17]
    !wp_off_r && !wp_armed_r |=> !wp_off_r)
    else $error("protection lifted without armed read");

endmodule

`default_nettype wire

// *** verilog/timer_regs_pkg.sv ***
// Constants for the timer start-value, flag-mirror and mode registers
// Notes on behaviour
// RL1: Start value written via buffer, loaded on update.
// RL2: First clock select starts counter at zero.
// RL3: Software loads start value before selecting clock.
// RL4: Start value in low sixteen bits only.
// RL5: Flag mirror shows every channel flag at once.
// RL6: Read then write zero clears all flags.
// RL7: Channel event sets its flag in hardware.
// RL8: Clear needs prior read; writing one ignored.
// RL9: Event between read and write keeps flag.
// RL10: Software uses mirror only in combine mode.
// RL11: Flags in bits seven..zero; upper bits zero.
// RL12: Mode 00 disables fault control on all channels.
// RL13: Fault interrupt only when enabled and active.
// RL14: Fault mode writable only without write protection.
// RL15: Mode 00 off; 01 even channels manual.
// RL16: Mode 10 all manual; 11 all automatic.
// RL17: Protect disable set after armed read; clear.
// RL18: Reserved bits ignore writes, read zero.
package timer_regs_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          CHANNELS        = 8;
  localparam int          START_W         = 16;

  localparam logic [7:0]  OFF_START_VALUE = 8'h4c;
  localparam logic [7:0]  OFF_FLAG_MIRROR = 8'h50;
  localparam logic [7:0]  OFF_MODE        = 8'h54;
  localparam logic [7:0]  OFF_PROTECT     = 8'h58;
  localparam logic [7:0]  OFF_CLOCK_SEL   = 8'h5c;
  localparam logic [7:0]  OFF_COUNTER     = 8'h60;

  localparam int          MODE_FIE_BIT    = 7;
  localparam int          MODE_FCM_LSB    = 5;
  localparam int          MODE_WP_OFF_BIT = 2;
  localparam int          PROT_WP_ON_BIT  = 0;
  localparam int          CLKSEL_W        = 2;

  localparam logic [15:0] START_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_FIRST     = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [1:0]  FCM_RESET       = 2'h0;
  localparam logic        FIE_RESET       = 1'b0;
  localparam logic        WP_OFF_RESET    = 1'b1;
  localparam logic [1:0]  CLKSEL_RESET    = 2'h0;

  localparam logic [1:0]  FCM_OFF         = 2'h0;
  localparam logic [1:0]  FCM_EVEN_MANUAL = 2'h1;
  localparam logic [1:0]  FCM_ALL_MANUAL  = 2'h2;
  localparam logic [1:0]  FCM_ALL_AUTO    = 2'h3;
  localparam logic [7:0]  EVEN_CHANNELS   = 8'h55;
  localparam logic [7:0]  ALL_CHANNELS    = 8'hff;

endpackage

// *** tb/timer_init_status_mode_regs_test.sv ***
// Self-checking bench for the start value, flag mirror and mode registers
`timescale 1ns/1ps
`default_nettype none

module timer_init_status_mode_regs_test;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic        buffer_update;
  logic [7:0]  channel_event;
  logic        fault_pin;
  logic [15:0] counter_initial_value;
  logic [1:0]  clock_source_select;
  logic        count_load;
  logic [15:0] count_load_value;
  logic [7:0]  channel_event_flag;
  logic [7:0]  fault_channel_enable;
  logic        fault_auto_clear;
  logic        fault_irq;
  int          num_errors;
  int          num_checks;
  int          i;
  logic [7:0]  flags;
  logic [7:0]  armed;
  logic [31:0] d;
  logic [31:0] d2;

  timer_init_status_mode_regs i_dut
  (
    .clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .buffer_update(buffer_update), .channel_event(channel_event),
    .fault_pin(fault_pin), .counter_initial_value(counter_initial_value),
    .clock_source_select(clock_source_select), .count_load(count_load),
    .count_load_value(count_load_value), .channel_event_flag(channel_event_flag),
    .fault_channel_enable(fault_channel_enable), .fault_auto_clear(fault_auto_clear),
    .fault_irq(fault_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [7:0] fcm_mask(input logic [1:0] m);
    return (m == 2'h0) ? 8'h00 : (m == 2'h1) ? 8'h55 : 8'hff;
  endfunction

  // Armed bits clear unless written one
  function automatic logic [7:0] after_clear(input logic [7:0] f, a, w);
    return f & ~(a & ~w);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Strobe dropped one edge later, so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic ev(input logic [7:0] e);
    @(posedge clk);
    channel_event <= e;
    @(posedge clk);
    channel_event <= 8'h00;
    #1;
    flags = flags | e;
  endtask

  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    flags = 8'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    num_errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    buffer_update = 1'b0;
    channel_event = 8'h00;
    fault_pin = 1'b0;
    d = $urandom(32'h3062b85c);
    do_reset();
    rd_chk(timer_regs_pkg::OFF_START_VALUE, 32'h0);
    rd_chk(timer_regs_pkg::OFF_FLAG_MIRROR, 32'h0);
    rd_chk(timer_regs_pkg::OFF_MODE, 32'h4);
    rd_chk(8'h70, 32'h0);
    // First clock select ignores the programmed start value
    d = $urandom();
    wr(timer_regs_pkg::OFF_START_VALUE, d);
    wr(timer_regs_pkg::OFF_CLOCK_SEL, 32'h1);
    chk(count_load, 1'b1);
    chk(count_load_value, 16'h0000);
    // Second reset mid-run; proper order loads the start value
    do_reset();
    d = $urandom();
    wr(timer_regs_pkg::OFF_START_VALUE, d);
    rd_chk(timer_regs_pkg::OFF_START_VALUE, {16'h0, d[15:0]});
    wr(timer_regs_pkg::OFF_COUNTER, $urandom());
    chk(count_load, 1'b1);
    chk(count_load_value, d[15:0]);
    wr(timer_regs_pkg::OFF_CLOCK_SEL, 32'h2);
    chk(count_load, 1'b0);
    chk(clock_source_select, 2'h2);
    rd_chk(timer_regs_pkg::OFF_CLOCK_SEL, 32'h2);
    // Buffered value waits for the update enable
    d2 = ~d;
    wr(timer_regs_pkg::OFF_START_VALUE, d2);
    repeat (3) @(posedge clk);
    #1;
    chk(counter_initial_value, d[15:0]);
    @(posedge clk);
    buffer_update <= 1'b1;
    @(posedge clk);
    buffer_update <= 1'b0;
    @(posedge clk);
    #1;
    chk(counter_initial_value, d2[15:0]);
    // Flag sets and read-then-write clears, with races
    for (i = 0; i < 24; i++)
    begin
      ev(8'($urandom()));
      chk(channel_event_flag, flags);
      rd_chk(timer_regs_pkg::OFF_FLAG_MIRROR, {24'h0, flags});
      armed = flags;
      d = $urandom();
      if (i % 3 == 1)
      begin
        ev(d[15:8]);
        armed = armed & ~d[15:8];
      end
      if (i % 3 == 0)
        d = 32'h0;
      wr(timer_regs_pkg::OFF_FLAG_MIRROR, d);
      flags = after_clear(flags, armed, d[7:0]);
      chk(channel_event_flag, flags);
    end
    // Read and zero write back to back, then an event between them
    ev(8'h3c);
    @(posedge clk);
    addr   <= timer_regs_pkg::OFF_FLAG_MIRROR;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    wdata  <= 32'h0;
    wr_stb <= 1'b1;
    #1;
    chk(rdata, {24'h0, flags});
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
    chk(channel_event_flag, 8'h00);
    flags = 8'h00;
    ev(8'h18);
    @(posedge clk);
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb        <= 1'b0;
    channel_event <= 8'h81;
    @(posedge clk);
    channel_event <= 8'h00;
    wr_stb        <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
    chk(channel_event_flag, 8'h81);
    flags = 8'h81;
    ev(8'hff);
    wr(timer_regs_pkg::OFF_FLAG_MIRROR, 32'h0);
    chk(channel_event_flag, 8'hff);
    rd_chk(timer_regs_pkg::OFF_FLAG_MIRROR, 32'hff);
    wr(timer_regs_pkg::OFF_FLAG_MIRROR, 32'h0);
    chk(channel_event_flag, 8'h00);
    // Every fault mode, fault interrupt gating
    for (i = 0; i < 8; i++)
    begin
      d = $urandom();
      d[7] = i[2];
      wr(timer_regs_pkg::OFF_MODE, {d[31:8], d[7], i[1:0], 5'b00100});
      rd_chk(timer_regs_pkg::OFF_MODE, {24'h0, d[7], i[1:0], 5'b00100});
      chk(fault_channel_enable, fcm_mask(i[1:0]));
      chk(fault_auto_clear, i[1:0] == 2'h3);
      @(posedge clk);
      fault_pin <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk(fault_irq, d[7] && i[1:0] != 2'h0);
      @(posedge clk);
      fault_pin <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(fault_irq, 1'b0);
    end
    // Protection: blocked write, armed re-enable, zero write ignored
    wr(timer_regs_pkg::OFF_PROTECT, 32'h1);
    rd_chk(timer_regs_pkg::OFF_MODE, 32'he0);
    wr(timer_regs_pkg::OFF_MODE, 32'ha4);
    rd_chk(timer_regs_pkg::OFF_PROTECT, 32'h1);
    chk(fault_channel_enable, 8'hff);
    chk(fault_auto_clear, 1'b1);
    wr(timer_regs_pkg::OFF_MODE, 32'he4);
    rd_chk(timer_regs_pkg::OFF_MODE, 32'he4);
    wr(timer_regs_pkg::OFF_MODE, 32'ha0);
    rd_chk(timer_regs_pkg::OFF_MODE, 32'ha4);
    chk(fault_channel_enable, 8'h55);
    finish_test();
  end

endmodule
`default_nettype wire
